// ---- adsc_control.sv ----
// Control register one of the converter, with status flags and interrupt line
// Function
// - Overrun flag with its enable raises interrupt
// - Width code selects bits and conversion length
// - Regular guard enable checks regular results
// - Injected guard enable checks injected results
// - Idle power-down bit powers down waiting converter
// - Delay power-down bit powers down during delay
// - Burst run length is count plus one
// - Injected burst enable selects discontinuous injected
// - Regular burst enable selects discontinuous regular
// - Chain bit starts injected after regular done
// - Single-channel bit guards only selected channel
// - Scan bit converts whole sequence lists
// - Injected done flag with enable raises interrupt
// - Guard enable gates interrupt and scan abort
// - Regular done flag with enable raises interrupt
// - Guarded channel codes above 26 are reserved
// - Hardware sets guard flag, software clears
// - Overrun detected only with memory mode or per-conversion
module adsc_control
    import adsc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    // Events from the converter core
    input adsc_result_type result,
    input wire logic regular_group_done,
    input wire logic injected_group_done,
    input wire logic data_lost,
    input wire logic idle_phase,
    input wire logic delay_phase,
    // Settings and commands to the converter core
    output adsc_conv_cfg_type conv_cfg,
    output logic start_injected,
    output logic abort_scan,
    // Interrupt request
    output logic irq
);

    adsc_ctrl_one_type ctrl_one;
    logic converter_on;
    logic dma_mode;
    logic per_conversion_done_sel;
    logic [ADSC_THR_W-1:0] low_thr;
    logic [ADSC_THR_W-1:0] high_thr;
    logic overrun_flag;
    logic regular_done_flag;
    logic injected_done_flag;
    logic guard_flag;
    logic guard_hit;
    logic wr_status;
    logic wr_ctrl_one;
    logic wr_ctrl_two;
    logic wr_low;
    logic wr_high;
    logic overrun_event;
    logic [31:0] next_rdata;
    logic [3:0] next_cycles;
    logic next_power_down;

    // Address decode for writes
    assign wr_status = reg_write && reg_addr == ADSC_OFS_STATUS;
    assign wr_ctrl_one = reg_write && reg_addr == ADSC_OFS_CTRL_ONE;
    assign wr_ctrl_two = reg_write && reg_addr == ADSC_OFS_CTRL_TWO;
    assign wr_low = reg_write && reg_addr == ADSC_OFS_LOW_THR;
    assign wr_high = reg_write && reg_addr == ADSC_OFS_HIGH_THR;

    // Control register one; reserved bits are forced to zero on write
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_one <= ADSC_CTRL_ONE_RESET;
        end
        else if (wr_ctrl_one)
        begin
            ctrl_one <= reg_wdata & ADSC_CTRL_ONE_MASK;
        end
    end

    // Control two holds the converter-on, memory-mode and per-conversion bits
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            converter_on <= ADSC_CTRL_TWO_RESET[ADSC_C2_CONV_ON];
            dma_mode <= ADSC_CTRL_TWO_RESET[ADSC_C2_DMA];
            per_conversion_done_sel <= ADSC_CTRL_TWO_RESET[ADSC_C2_PER_CONV];
        end
        else if (wr_ctrl_two)
        begin
            converter_on <= reg_wdata[ADSC_C2_CONV_ON];
            dma_mode <= reg_wdata[ADSC_C2_DMA];
            per_conversion_done_sel <= reg_wdata[ADSC_C2_PER_CONV];
        end
    end

    // Guard window thresholds
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            low_thr <= ADSC_LOW_THR_RESET;
            high_thr <= ADSC_HIGH_THR_RESET;
        end
        else
        begin
            if (wr_low)
            begin
                low_thr <= reg_wdata[ADSC_THR_W-1:0];
            end
            if (wr_high)
            begin
                high_thr <= reg_wdata[ADSC_THR_W-1:0];
            end
        end
    end

    // Result window check
    adsc_guard u_guard (
        .clk(clk),
        .rst(rst),
        .result(result),
        .regular_guard_en(ctrl_one.regular_guard_en),
        .injected_guard_en(ctrl_one.injected_guard_en),
        .guard_single_chan(ctrl_one.guard_single_chan),
        .guard_chan_sel(ctrl_one.guard_chan_sel),
        .low_thr(low_thr),
        .high_thr(high_thr),
        .hit(guard_hit)
    );

    // Lost data only counts when someone is expected to collect every result
    assign overrun_event = data_lost && (dma_mode || per_conversion_done_sel);

    // Sticky flags: writing 0 clears, writing 1 keeps; a new event beats the clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            overrun_flag <= 1'b0;
            regular_done_flag <= 1'b0;
            injected_done_flag <= 1'b0;
            guard_flag <= 1'b0;
        end
        else
        begin
            if (overrun_event)
            begin
                overrun_flag <= 1'b1;
            end
            else if (wr_status && !reg_wdata[ADSC_ST_OVERRUN])
            begin
                overrun_flag <= 1'b0;
            end
            if (regular_group_done)
            begin
                regular_done_flag <= 1'b1;
            end
            else if (wr_status && !reg_wdata[ADSC_ST_REG_DONE])
            begin
                regular_done_flag <= 1'b0;
            end
            if (injected_group_done)
            begin
                injected_done_flag <= 1'b1;
            end
            else if (wr_status && !reg_wdata[ADSC_ST_INJ_DONE])
            begin
                injected_done_flag <= 1'b0;
            end
            // No data-read clear here; only software drops the guard flag
            if (guard_hit)
            begin
                guard_flag <= 1'b1;
            end
            else if (wr_status && !reg_wdata[ADSC_ST_GUARD])
            begin
                guard_flag <= 1'b0;
            end
        end
    end

    // Conversion length for the selected width
    always_comb
    begin
        case (ctrl_one.conv_width)
            ADSC_WIDTH_12: next_cycles = ADSC_CYC_12;
            ADSC_WIDTH_10: next_cycles = ADSC_CYC_10;
            ADSC_WIDTH_8: next_cycles = ADSC_CYC_8;
            ADSC_WIDTH_6: next_cycles = ADSC_CYC_6;
            default: next_cycles = ADSC_CYC_12;
        endcase
    end

    // Power state: off when disabled, else per phase and its power-down bit
    always_comb
    begin
        if (!converter_on)
        begin
            next_power_down = 1'b1;
        end
        else if (idle_phase)
        begin
            next_power_down = ctrl_one.idle_powerdown;
        end
        else if (delay_phase)
        begin
            next_power_down = ctrl_one.delay_powerdown;
        end
        else
        begin
            next_power_down = 1'b0;
        end
    end

    // Settings are sampled every cycle; software only changes them while off
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            // Powered down with a one-channel burst until set up
            conv_cfg.converter_on <= 1'b0;
            conv_cfg.power_down <= 1'b1;
            conv_cfg.conv_width <= 2'h0;
            conv_cfg.conv_cycles <= 4'h0;
            conv_cfg.scan_en <= 1'b0;
            conv_cfg.regular_burst_en <= 1'b0;
            conv_cfg.injected_burst_en <= 1'b0;
            conv_cfg.burst_len <= 4'h1;
        end
        else
        begin
            conv_cfg.converter_on <= converter_on;
            conv_cfg.power_down <= next_power_down;
            conv_cfg.conv_width <= ctrl_one.conv_width;
            conv_cfg.conv_cycles <= next_cycles;
            conv_cfg.scan_en <= ctrl_one.scan_en;
            conv_cfg.regular_burst_en <= ctrl_one.regular_burst_en;
            conv_cfg.injected_burst_en <= ctrl_one.injected_burst_en;
            conv_cfg.burst_len <= {1'b0, ctrl_one.burst_chan_count} + 4'h1;
        end
    end

    // Chained injected start after a regular group, while the converter is on
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            start_injected <= 1'b0;
        end
        else
        begin
            // A chained start while off would wake a dead converter
            start_injected <= regular_group_done && converter_on
                && ctrl_one.chain_injected_after_regular;
        end
    end

    // Scan is aborted on a crossing only when the guard interrupt is enabled
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            abort_scan <= 1'b0;
        end
        else
        begin
            abort_scan <= guard_hit && ctrl_one.scan_en && ctrl_one.guard_irq_en;
        end
    end

    // One interrupt line; a level that follows the flags one cycle later
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= (overrun_flag && ctrl_one.overrun_irq_en)
                || (regular_done_flag && ctrl_one.conv_done_irq_en)
                || (injected_done_flag && ctrl_one.injected_done_irq_en)
                || (guard_flag && ctrl_one.guard_irq_en);
        end
    end

    // Read multiplexer; unmapped offsets read zero
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        case (reg_addr)
            ADSC_OFS_STATUS:
            begin
                next_rdata[ADSC_ST_OVERRUN] = overrun_flag;
                next_rdata[ADSC_ST_INJ_DONE] = injected_done_flag;
                next_rdata[ADSC_ST_REG_DONE] = regular_done_flag;
                next_rdata[ADSC_ST_GUARD] = guard_flag;
            end
            // Reserved bits were dropped on write, so they read zero
            ADSC_OFS_CTRL_ONE: next_rdata = ctrl_one;
            ADSC_OFS_CTRL_TWO:
            begin
                next_rdata[ADSC_C2_CONV_ON] = converter_on;
                next_rdata[ADSC_C2_DMA] = dma_mode;
                next_rdata[ADSC_C2_PER_CONV] = per_conversion_done_sel;
            end
            ADSC_OFS_LOW_THR: next_rdata[ADSC_THR_W-1:0] = low_thr;
            ADSC_OFS_HIGH_THR: next_rdata[ADSC_THR_W-1:0] = high_thr;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Read data stand only in the cycle after the strobe, zero otherwise
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= 32'h0000_0000;
        end
        else if (reg_read)
        begin
            reg_rdata <= next_rdata;
        end
        else
        begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule : adsc_control

// ---- adsc_control_asserts.sv ----
// Checker for the converter control register block and its bind
module adsc_control_asserts
    import adsc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    // Converter side
    input adsc_result_type result,
    input wire logic regular_group_done,
    input wire logic injected_group_done,
    input wire logic data_lost,
    input wire logic idle_phase,
    input wire logic delay_phase,
    input adsc_conv_cfg_type conv_cfg,
    input wire logic start_injected,
    input wire logic abort_scan,
    input wire logic irq
);
    adsc_ctrl_one_type sh_one;
    logic sh_on;
    logic sh_dma;
    logic [11:0] sh_low;
    logic [11:0] sh_high;
    logic warm;
    logic crossing;

    // Shadow of the software settings, rebuilt from observed writes
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sh_one <= ADSC_CTRL_ONE_RESET;
            sh_on <= 1'b0;
            sh_dma <= 1'b0;
            sh_low <= ADSC_LOW_THR_RESET;
            sh_high <= ADSC_HIGH_THR_RESET;
        end
        else if (reg_write)
        begin
            if (reg_addr == ADSC_OFS_CTRL_ONE)
                sh_one <= reg_wdata & ADSC_CTRL_ONE_MASK;
            if (reg_addr == ADSC_OFS_CTRL_TWO)
                sh_on <= reg_wdata[ADSC_C2_CONV_ON];
            if (reg_addr == ADSC_OFS_CTRL_TWO)
                sh_dma <= reg_wdata[ADSC_C2_DMA] | reg_wdata[ADSC_C2_PER_CONV];
            if (reg_addr == ADSC_OFS_LOW_THR)
                sh_low <= reg_wdata[11:0];
            if (reg_addr == ADSC_OFS_HIGH_THR)
                sh_high <= reg_wdata[11:0];
        end
    end

    // Outputs still show reset values at the first edge after release
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            warm <= 1'b0;
        else
            warm <= 1'b1;
    end

    // A result that the guard must flag under the present settings
    assign crossing = result.valid && (result.injected ? sh_one.injected_guard_en : sh_one.regular_guard_en)
        && (!sh_one.guard_single_chan || (result.chan == sh_one.guard_chan_sel && sh_one.guard_chan_sel <= ADSC_LAST_CHAN))
        && (result.value < sh_low || result.value > sh_high);

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    rdata_rsvd_a:
        assert property ($past(reg_read) && $past(reg_addr) == ADSC_OFS_CTRL_ONE |-> reg_rdata[31:27] == 5'h0 && reg_rdata[21:18] == 4'h0)
        else $error("reserved control bits read back nonzero");
    width_follow_a:
        assert property (conv_cfg.conv_width == $past(sh_one.conv_width))
        else $error("conversion width not passed on");
    cycles_map_a:
        assert property (warm |-> conv_cfg.conv_cycles == (conv_cfg.conv_width == ADSC_WIDTH_12 ? ADSC_CYC_12 :
            conv_cfg.conv_width == ADSC_WIDTH_10 ? ADSC_CYC_10 : conv_cfg.conv_width == ADSC_WIDTH_8 ? ADSC_CYC_8 : ADSC_CYC_6))
        else $error("conversion length does not match width");
    burst_len_a:
        assert property (conv_cfg.burst_len == {1'b0, $past(sh_one.burst_chan_count)} + 4'h1)
        else $error("burst length is not count plus one");
    burst_mode_a:
        assert property (conv_cfg.regular_burst_en == $past(sh_one.regular_burst_en)
            && conv_cfg.injected_burst_en == $past(sh_one.injected_burst_en))
        else $error("burst enables not passed on");
    scan_follow_a:
        assert property (conv_cfg.scan_en == $past(sh_one.scan_en))
        else $error("scan enable not passed on");
    power_mode_a:
        assert property (conv_cfg.power_down == (!$past(sh_on) || ($past(idle_phase) ? $past(sh_one.idle_powerdown)
            : $past(delay_phase) && $past(sh_one.delay_powerdown))))
        else $error("power down state wrong");
    chain_start_a:
        assert property (start_injected == ($past(regular_group_done) && $past(sh_one.chain_injected_after_regular) && $past(sh_on)))
        else $error("chained injected start wrong");
    overrun_irq_a:
        assert property (data_lost && sh_dma && sh_one.overrun_irq_en |-> ##2 irq)
        else $error("overrun did not raise irq");
    done_irq_a:
        assert property ((injected_group_done && sh_one.injected_done_irq_en) || (regular_group_done && sh_one.conv_done_irq_en)
            |-> ##2 irq)
        else $error("group done did not raise irq");
    guard_irq_a:
        assert property (crossing && sh_one.guard_irq_en |-> ##[2:4] irq)
        else $error("guard crossing did not raise irq");
    scan_abort_a:
        assert property (crossing && sh_one.guard_irq_en && sh_one.scan_en |-> ##[1:3] abort_scan)
        else $error("guard crossing did not abort scan");
    abort_cause_a:
        assert property (abort_scan |-> $past(sh_one.guard_irq_en) && $past(sh_one.scan_en))
        else $error("scan aborted without enables");
    irq_fall_a:
        assert property ($fell(irq) |-> $past(reg_write, 2))
        else $error("irq dropped without a software write");
endmodule : adsc_control_asserts

bind adsc_control adsc_control_asserts i_chk (.clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .result, .regular_group_done, .injected_group_done, .data_lost, .idle_phase, .delay_phase, .conv_cfg,
    .start_injected, .abort_scan, .irq);

// ---- adsc_control_bench.sv ----
// Self-checking bench for the converter control register block
module adsc_control_bench
    import adsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rst, reg_write, reg_read, regular_group_done, injected_group_done, data_lost, idle_phase, delay_phase;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic start_injected, abort_scan, irq;
    adsc_result_type result;
    adsc_conv_cfg_type conv_cfg;
    int fails = 0;
    int n_tests = 0;
    int seed = 32'h2beca653;
    int n_abort = 0;
    int n_start = 0;

    adsc_control i_dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .result,
        .regular_group_done, .injected_group_done, .data_lost, .idle_phase, .delay_phase, .conv_cfg,
        .start_injected, .abort_scan, .irq);

    // Clock at 250 MHz
    always #2 clk = ~clk;

    // Pulses are counted so that checks do not hinge on their exact cycle
    always @(posedge clk)
    begin
        if (abort_scan === 1'b1)
            n_abort++;
        if (start_injected === 1'b1)
            n_start++;
    end

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    // One-cycle event pulses from the converter core
    task automatic ev(logic [2:0] s, adsc_result_type r);
        @(posedge clk);
        {regular_group_done, injected_group_done, data_lost} <= s;
        result <= r;
        @(posedge clk);
        {regular_group_done, injected_group_done, data_lost} <= 3'b000;
        result <= '0;
    endtask : ev

    function automatic logic [3:0] cyc(logic [1:0] w);
        return w == 2'h0 ? 4'hC : w == 2'h1 ? 4'hB : w == 2'h2 ? 4'h9 : 4'h7;
    endfunction : cyc

    // Thresholds used below are 0x100 and 0x800
    function automatic logic gexp(adsc_ctrl_one_type c, adsc_result_type r);
        return (r.injected ? c.injected_guard_en : c.regular_guard_en) && (r.value < 12'h100 || r.value > 12'h800)
            && (!c.guard_single_chan || (r.chan == c.guard_chan_sel && c.guard_chan_sel <= 5'h1A));
    endfunction : gexp

    task automatic conclude;
        if (fails == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    // Cut a hang short well beyond the expected run length
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        conclude();
    end

    // Main sequence
    initial
    begin
        logic [31:0] d;
        adsc_ctrl_one_type c;
        adsc_result_type r;
        clk = 1'b0;
        rst = 1'b1;
        {reg_write, reg_read, regular_group_done, injected_group_done, data_lost, idle_phase, delay_phase} = '0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0000_0000;
        result = '0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(ADSC_OFS_CTRL_ONE, d);
        check("ctrl_one reset", d, ADSC_CTRL_ONE_RESET);
        rd(ADSC_OFS_HIGH_THR, d);
        check("high thr reset", d, 32'h0000_0FFF);
        rd(8'h14, d);
        check("unmapped read", d, 32'h0000_0000);
        // Settings change only while the converter is off; all width codes seen
        for (int i = 0; i < 16; i++)
        begin
            d = $random(seed);
            d[25:24] = i[1:0];
            wr(ADSC_OFS_CTRL_ONE, d);
            c = d & ADSC_CTRL_ONE_MASK;
            rd(ADSC_OFS_CTRL_ONE, d);
            check("ctrl_one", d, c);
            check("cycles", 32'(conv_cfg.conv_cycles), 32'(cyc(c.conv_width)));
            check("burst len", 32'(conv_cfg.burst_len), 32'(c.burst_chan_count) + 1);
            check("regular burst", 32'(conv_cfg.regular_burst_en), 32'(c.regular_burst_en));
            check("injected burst", 32'(conv_cfg.injected_burst_en), 32'(c.injected_burst_en));
            check("scan", 32'(conv_cfg.scan_en), 32'(c.scan_en));
        end
        // Power state in idle and delay phases
        for (int i = 0; i < 8; i++)
        begin
            wr(ADSC_OFS_CTRL_TWO, 32'h0000_0000);
            c = '0;
            c.idle_powerdown = i[0];
            c.delay_powerdown = i[1];
            wr(ADSC_OFS_CTRL_ONE, c);
            wr(ADSC_OFS_CTRL_TWO, 32'h0000_0001);
            idle_phase <= i[2];
            delay_phase <= !i[2];
            repeat (3) @(posedge clk);
            #1 check("power down", 32'(conv_cfg.power_down), 32'(i[2] ? i[0] : i[1]));
            check("converter on", 32'(conv_cfg.converter_on), 32'h0000_0001);
        end
        idle_phase <= 1'b0;
        delay_phase <= 1'b0;
        wr(ADSC_OFS_CTRL_TWO, 32'h0000_0000);
        c = '0;
        c.chain_injected_after_regular = 1'b1;
        c.conv_done_irq_en = 1'b1;
        c.injected_done_irq_en = 1'b1;
        c.overrun_irq_en = 1'b1;
        wr(ADSC_OFS_CTRL_ONE, c);
        wr(ADSC_OFS_CTRL_TWO, 32'h0000_0001);
        // Lost data is not flagged without memory mode
        ev(3'b001, '0);
        repeat (3) @(posedge clk);
        rd(ADSC_OFS_STATUS, d);
        check("overrun refused", d, 32'h0000_0000);
        wr(ADSC_OFS_CTRL_TWO, 32'h0000_0101);
        // Regular done, injected done, then overrun in memory mode and again in per-conversion mode
        for (int k = 0; k < 4; k++)
        begin
            n_start = 0;
            if (k == 3) wr(ADSC_OFS_CTRL_TWO, 32'h0000_0401);
            ev(k == 3 ? 3'b001 : 3'b100 >> k, '0);
            repeat (3) @(posedge clk);
            rd(ADSC_OFS_STATUS, d);
            check("event flag", d, k == 0 ? 32'h0000_0002 : k == 1 ? 32'h0000_0004 : 32'h0000_0020);
            check("event irq", 32'(irq), 32'h0000_0001);
            check("chained start", 32'(n_start), 32'(k == 0));
            wr(ADSC_OFS_STATUS, 32'h0000_0000);
            repeat (3) @(posedge clk);
            #1 check("irq cleared", 32'(irq), 32'h0000_0000);
        end
        wr(ADSC_OFS_CTRL_TWO, 32'h0000_0000);
        wr(ADSC_OFS_LOW_THR, 32'h0000_0100);
        wr(ADSC_OFS_HIGH_THR, 32'h0000_0800);
        // Guard over random settings; the first pass guards a reserved channel
        for (int i = 0; i < 40; i++)
        begin
            d = $random(seed);
            c = '0;
            {c.scan_en, c.guard_irq_en, c.guard_single_chan, c.injected_guard_en, c.regular_guard_en} = d[4:0];
            c.guard_chan_sel = 5'(d[9:5] % 27);
            r = '0;
            r.valid = 1'b1;
            r.injected = d[10];
            r.chan = d[11] ? c.guard_chan_sel : d[16:12];
            r.value = d[28:17];
            if (i == 0)
                c = 32'h00C0_025B;
            if (i == 0)
                r.chan = 5'h1B;
            wr(ADSC_OFS_CTRL_ONE, c);
            wr(ADSC_OFS_STATUS, 32'h0000_0000);
            n_abort = 0;
            ev(3'b000, r);
            repeat (5) @(posedge clk);
            rd(ADSC_OFS_STATUS, d);
            check("guard flag", d, 32'(gexp(c, r)));
            check("guard irq", 32'(irq), 32'(gexp(c, r) & c.guard_irq_en));
            check("scan abort", 32'(n_abort), 32'(gexp(c, r) & c.guard_irq_en & c.scan_en));
        end
        conclude();
    end
endmodule : adsc_control_bench

// ---- adsc_guard.sv ----
// Window comparator that watches converted results
module adsc_guard
    import adsc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Result and settings
    input adsc_result_type result,
    input wire logic regular_guard_en,
    input wire logic injected_guard_en,
    input wire logic guard_single_chan,
    input wire logic [4:0] guard_chan_sel,
    input wire logic [ADSC_THR_W-1:0] low_thr,
    input wire logic [ADSC_THR_W-1:0] high_thr,
    // One-cycle pulse on a threshold crossing
    output logic hit
);

    logic group_on;
    logic chan_on;
    logic outside;

    // Each group is guarded only when its own enable is set
    assign group_on = result.injected ? injected_guard_en : regular_guard_en;
    // Reserved channel codes never match, so nothing is guarded then
    assign chan_on = !guard_single_chan
        || (guard_chan_sel <= ADSC_LAST_CHAN && result.chan == guard_chan_sel);
    assign outside = (result.value < low_thr) || (result.value > high_thr);

    // Registered so the flag logic sees a clean single pulse
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            hit <= 1'b0;
        end
        else
        begin
            hit <= result.valid && group_on && chan_on && outside;
        end
    end

endmodule : adsc_guard

// ---- adsc_pkg.sv ----
// Shared constants and types for the converter sequencing control block
package adsc_pkg;

    // Register byte offsets
    localparam logic [7:0] ADSC_OFS_STATUS = 8'h00;
    localparam logic [7:0] ADSC_OFS_CTRL_ONE = 8'h04;
    localparam logic [7:0] ADSC_OFS_CTRL_TWO = 8'h08;
    localparam logic [7:0] ADSC_OFS_LOW_THR = 8'h0C;
    localparam logic [7:0] ADSC_OFS_HIGH_THR = 8'h10;

    // Reset values
    localparam logic [31:0] ADSC_CTRL_ONE_RESET = 32'h0000_0000;
    localparam logic [31:0] ADSC_CTRL_TWO_RESET = 32'h0000_0000;
    localparam logic [11:0] ADSC_LOW_THR_RESET = 12'h000;
    localparam logic [11:0] ADSC_HIGH_THR_RESET = 12'hFFF;

    // Writable bits of control one; reserved ranges 31:27 and 21:18 stay zero
    localparam logic [31:0] ADSC_CTRL_ONE_MASK = 32'h07C3_FFFF;

    // Status bit positions
    localparam int ADSC_ST_GUARD = 0;
    localparam int ADSC_ST_REG_DONE = 1;
    localparam int ADSC_ST_INJ_DONE = 2;
    localparam int ADSC_ST_OVERRUN = 5;

    // Control two bit positions
    localparam int ADSC_C2_CONV_ON = 0;
    localparam int ADSC_C2_DMA = 8;
    localparam int ADSC_C2_PER_CONV = 10;

    // Threshold width and highest legal guarded channel
    localparam int ADSC_THR_W = 12;
    localparam logic [4:0] ADSC_LAST_CHAN = 5'h1A;

    // Conversion width codes and their lengths in converter clock cycles
    localparam logic [1:0] ADSC_WIDTH_12 = 2'h0;
    localparam logic [1:0] ADSC_WIDTH_10 = 2'h1;
    localparam logic [1:0] ADSC_WIDTH_8 = 2'h2;
    localparam logic [1:0] ADSC_WIDTH_6 = 2'h3;
    localparam logic [3:0] ADSC_CYC_12 = 4'hC;
    localparam logic [3:0] ADSC_CYC_10 = 4'hB;
    localparam logic [3:0] ADSC_CYC_8 = 4'h9;
    localparam logic [3:0] ADSC_CYC_6 = 4'h7;

    // Layout of control register one
    typedef struct packed {
        logic [4:0] rsvd_hi;
        logic overrun_irq_en;
        logic [1:0] conv_width;
        logic regular_guard_en;
        logic injected_guard_en;
        logic [3:0] rsvd_mid;
        logic idle_powerdown;
        logic delay_powerdown;
        logic [2:0] burst_chan_count;
        logic injected_burst_en;
        logic regular_burst_en;
        logic chain_injected_after_regular;
        logic guard_single_chan;
        logic scan_en;
        logic injected_done_irq_en;
        logic guard_irq_en;
        logic conv_done_irq_en;
        logic [4:0] guard_chan_sel;
    } adsc_ctrl_one_type;

    // One converted result from the converter core
    typedef struct packed {
        logic valid;
        logic injected;
        logic [4:0] chan;
        logic [ADSC_THR_W-1:0] value;
    } adsc_result_type;

    // Configuration presented to the converter core
    typedef struct packed {
        logic converter_on;
        logic power_down;
        logic [1:0] conv_width;
        logic [3:0] conv_cycles;
        logic scan_en;
        logic regular_burst_en;
        logic injected_burst_en;
        logic [3:0] burst_len;
    } adsc_conv_cfg_type;

endpackage : adsc_pkg
